/* File: verilog/fhss_pkg.sv */
// Constants and types shared by the floppy head stepper sequencer files.
package fhss_pkg;

  // Clock and widths.
  localparam int CLK_PERIOD_NS = 100;
  localparam int CNT_W         = 16;
  localparam int STEP_W        = 20;

  // Step geometry: eighth-track steps, overshoot, eject run-out, rezero limit.
  localparam logic [STEP_W-1:0] TRACK_STEPS      = 20'h0_0008;
  localparam logic [STEP_W-1:0] OVERSHOOT_STEPS  = 20'h0_0004;
  localparam logic [CNT_W-1:0]  EJECT_TRACKS     = 16'h0009;
  localparam logic [STEP_W-1:0] REZERO_MAX_STEPS = 20'h0_0320;

  // Logical phase pairs that open a movement in each direction.
  localparam logic [1:0] FWD_START_PAIR = 2'h3;
  localparam logic [1:0] REV_START_PAIR = 2'h0;

  // Settle time of the sense line after the select lines change.
  localparam int SENSE_SETTLE_NS = 1000;
  localparam logic [CNT_W-1:0] SENSE_SETTLE_CYC =
    CNT_W'((SENSE_SETTLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);

  // Commands taken from the user side.
  typedef enum logic [2:0]
  {
    OP_SEEK       = 3'h0,
    OP_REZERO     = 3'h1,
    OP_EJECT      = 3'h2,
    OP_SENSE_DISK = 3'h3,
    OP_SENSE_WP   = 3'h4
  } fhss_op_e;

  // Sequencer states.
  typedef enum logic [1:0]
  {
    ST_IDLE  = 2'h0,
    ST_MOVE  = 2'h1,
    ST_HOLD  = 2'h2,
    ST_SENSE = 2'h3
  } fhss_state_e;

  // Whole state of the sequencer.
  typedef struct packed
  {
    fhss_state_e       state;
    fhss_op_e          op;
    logic              dir;
    logic              overshoot;
    logic              eject_tail;
    logic [STEP_W-1:0] steps_left;
    logic [1:0]        pair;
    logic [3:0]        phases;
    logic              head_sel;
    logic              ready;
    logic              done;
    logic              result;
    logic              cal_found;
    logic              sense_m;
    logic              sense_q;
    logic              cal_m;
    logic              cal_q;
  } fhss_ctl_s;

  localparam fhss_ctl_s CTL_RESET = '{state: ST_IDLE, op: OP_SEEK, default: '0};

  // Whole state of the period timer.
  typedef struct packed
  {
    logic [CNT_W-1:0] cnt;
  } fhss_tmr_s;

  localparam fhss_tmr_s TMR_RESET = '{cnt: 16'h0000};

endpackage

/* File: verilog/fhss_timer_if.sv */
// Link between the sequencer and its step period timer.
interface fhss_timer_if;
  logic                       load;
  logic [fhss_pkg::CNT_W-1:0] period;
  logic                       expired;

  modport ctl (output load, output period, input expired);
  modport tmr (input load, input period, output expired);
endinterface

/* File: verilog/fhss_step_timer.sv */
// Down counter that times each phase pattern of the stepper.
module fhss_step_timer
(
  input  wire logic  clk_sys,
  input  wire logic  reset,
  fhss_timer_if.tmr  tif
);

  fhss_pkg::fhss_tmr_s st;
  fhss_pkg::fhss_tmr_s next_st;

  // A load of P makes expired high in the P-th cycle after the load edge.
  // A period of zero is taken as one so the sequencer can never hang.
  always_comb
  begin
    next_st = st;
    if (tif.load)
    begin
      next_st.cnt = (tif.period == 16'h0000) ? 16'h0001 : tif.period;
    end
    else if (st.cnt != 16'h0000)
    begin
      next_st.cnt = st.cnt - 16'h0001;
    end
  end

  // State register.
  always_ff @(posedge clk_sys)
  begin
    if (reset)
    begin
      st <= fhss_pkg::TMR_RESET;
    end
    else
    begin
      st <= next_st;
    end
  end

  assign tif.expired = (st.cnt == 16'h0001);

endmodule

/* File: verilog/fhss_sequencer.sv */
// Host-side stepper phase sequencer, sense poller and eject driver for a floppy drive.
module fhss_sequencer
(
  input  wire logic        clk_sys,
  input  wire logic        reset,
  input  wire logic        cmd_valid,
  input  wire logic [2:0]  cmd_op,
  input  wire logic        cmd_reverse,
  input  wire logic [15:0] cmd_count,
  input  wire logic        cmd_in_tracks,
  input  wire logic [15:0] period_accel,
  input  wire logic [15:0] period_run,
  input  wire logic [15:0] period_decel,
  input  wire logic [7:0]  phase_order,
  input  wire logic        sense_pin,
  input  wire logic        calib_pin,
  output logic             cmd_ready,
  output logic             cmd_done,
  output logic             sense_result,
  output logic             cal_found,
  output logic             stepper_phase_a,
  output logic             stepper_phase_b,
  output logic             stepper_phase_c,
  output logic             stepper_phase_d,
  output logic             head_choice_line
);

  fhss_pkg::fhss_ctl_s st;
  fhss_pkg::fhss_ctl_s next_st;
  fhss_timer_if        tif ();

  // Physical line of a logical phase, as the programmable order maps it.
  function automatic logic [3:0] line_of(input logic [1:0] idx, input logic [7:0] order);
    logic [1:0] sel;
    sel = order[{idx, 1'b0} +: 2];
    return 4'h1 << sel;
  endfunction

  // Lines of a logical pair: phase idx and the next one round the ring.
  function automatic logic [3:0] pair_lines(input logic [1:0] idx, input logic [7:0] order);
    logic [1:0] nxt;
    nxt = idx + 2'h1;
    return line_of(idx, order) | line_of(nxt, order);
  endfunction

  // Command count in eighth-track steps.
  function automatic logic [19:0] to_steps(input logic [15:0] cnt, input logic trk);
    logic [19:0] c;
    c = 20'(cnt);
    return trk ? 20'(c * fhss_pkg::TRACK_STEPS) : c;
  endfunction

  // Opens a movement on the start pair of the chosen direction.
  function automatic fhss_pkg::fhss_ctl_s start_move(input fhss_pkg::fhss_ctl_s s,
                                                      input logic rev,
                                                      input logic [19:0] n,
                                                      input logic [7:0] order);
    fhss_pkg::fhss_ctl_s r;
    r = s;
    r.state = fhss_pkg::ST_MOVE;
    r.dir = rev;
    r.pair = rev ? fhss_pkg::REV_START_PAIR : fhss_pkg::FWD_START_PAIR;
    r.phases = pair_lines(r.pair, order);
    r.steps_left = n;
    r.head_sel = 1'b0;
    return r;
  endfunction

  // Next-state logic; the timer is loaded in the same cycle a pattern changes.
  always_comb
  begin
    next_st = st;
    tif.load = 1'b0;
    tif.period = period_run;
    next_st.done = 1'b0;
    next_st.sense_m = sense_pin;
    next_st.sense_q = st.sense_m;
    next_st.cal_m = calib_pin;
    next_st.cal_q = st.cal_m;
    case (st.state)
      fhss_pkg::ST_IDLE:
      begin
        next_st.phases = 4'h0;
        next_st.head_sel = 1'b0;
        next_st.ready = 1'b1;
        if (cmd_valid && st.ready)
        begin
          next_st.ready = 1'b0;
          next_st.op = fhss_pkg::fhss_op_e'(cmd_op);
          next_st.overshoot = 1'b0;
          next_st.eject_tail = 1'b0;
          tif.load = 1'b1;
          tif.period = period_accel;
          case (cmd_op)
            fhss_pkg::OP_SEEK:
            begin
              // Small offsets for read retries are plain seeks in step units.
              if (cmd_reverse)
              begin
                next_st = start_move(next_st, 1'b1,
                                     to_steps(cmd_count, cmd_in_tracks)
                                     + fhss_pkg::OVERSHOOT_STEPS, phase_order);
                next_st.overshoot = 1'b1;
              end
              else
              begin
                next_st = start_move(next_st, 1'b0, to_steps(cmd_count, cmd_in_tracks),
                                     phase_order);
              end
            end
            fhss_pkg::OP_REZERO:
            begin
              next_st.cal_found = 1'b0;
              next_st = start_move(next_st, 1'b0, fhss_pkg::REZERO_MAX_STEPS, phase_order);
            end
            fhss_pkg::OP_EJECT:
            begin
              next_st = start_move(next_st, 1'b1, fhss_pkg::TRACK_STEPS, phase_order);
            end
            fhss_pkg::OP_SENSE_DISK, fhss_pkg::OP_SENSE_WP:
            begin
              next_st.state = fhss_pkg::ST_SENSE;
              next_st.head_sel = (cmd_op == fhss_pkg::OP_SENSE_DISK);
              next_st.phases = (cmd_op == fhss_pkg::OP_SENSE_DISK) ?
                               line_of(2'h0, phase_order) : 4'h0;
              tif.period = fhss_pkg::SENSE_SETTLE_CYC;
            end
            default:
            begin
              // Unknown codes are dropped without a done pulse.
              next_st.ready = 1'b1;
              tif.load = 1'b0;
            end
          endcase
        end
      end
      fhss_pkg::ST_MOVE:
      begin
        if (tif.expired)
        begin
          tif.load = 1'b1;
          if (st.steps_left == 20'h0_0000 ||
              (st.op == fhss_pkg::OP_REZERO && st.cal_q))
          begin
            // Phase a alone parks the carriage for one deceleration period.
            next_st.cal_found = (st.op == fhss_pkg::OP_REZERO) && st.cal_q;
            next_st.state = fhss_pkg::ST_HOLD;
            next_st.phases = line_of(2'h0, phase_order);
            tif.period = period_decel;
          end
          else
          begin
            next_st.pair = st.dir ? st.pair + 2'h1 : st.pair - 2'h1;
            next_st.phases = pair_lines(next_st.pair, phase_order);
            next_st.steps_left = st.steps_left - 20'h0_0001;
            tif.period = (st.steps_left == 20'h0_0001) ? period_decel : period_run;
          end
        end
      end
      fhss_pkg::ST_HOLD:
      begin
        if (tif.expired)
        begin
          next_st.phases = 4'h0;
          if (st.overshoot)
          begin
            // Ending forward takes up the carriage backlash in one direction only.
            next_st = start_move(next_st, 1'b0, fhss_pkg::OVERSHOOT_STEPS,
                                 phase_order);
            next_st.overshoot = 1'b0;
            tif.load = 1'b1;
            tif.period = period_accel;
          end
          else if (st.op == fhss_pkg::OP_EJECT && !st.eject_tail)
          begin
            next_st.state = fhss_pkg::ST_SENSE;
            next_st.head_sel = 1'b1;
            next_st.phases = line_of(2'h0, phase_order);
            tif.load = 1'b1;
            tif.period = fhss_pkg::SENSE_SETTLE_CYC;
          end
          else
          begin
            next_st.state = fhss_pkg::ST_IDLE;
            next_st.done = 1'b1;
            next_st.ready = 1'b1;
          end
        end
      end
      fhss_pkg::ST_SENSE:
      begin
        if (tif.expired)
        begin
          if (st.op == fhss_pkg::OP_EJECT)
          begin
            tif.load = 1'b1;
            tif.period = period_accel;
            if (st.sense_q)
            begin
              next_st = start_move(next_st, 1'b1, fhss_pkg::TRACK_STEPS, phase_order);
            end
            else
            begin
              next_st = start_move(next_st, 1'b1, to_steps(fhss_pkg::EJECT_TRACKS, 1'b1),
                                   phase_order);
              next_st.eject_tail = 1'b1;
            end
          end
          else
          begin
            next_st.result = st.sense_q;
            next_st.state = fhss_pkg::ST_IDLE;
            next_st.phases = 4'h0;
            next_st.head_sel = 1'b0;
            next_st.done = 1'b1;
            next_st.ready = 1'b1;
          end
        end
      end
      default:
      begin
        next_st.state = fhss_pkg::ST_IDLE;
      end
    endcase
  end

  // State register; the sense and calibration pins pass two flops here.
  always_ff @(posedge clk_sys)
  begin
    if (reset)
    begin
      st <= fhss_pkg::CTL_RESET;
    end
    else
    begin
      st <= next_st;
    end
  end

  fhss_step_timer u_timer
  (
    .clk_sys (clk_sys),
    .reset   (reset),
    .tif     (tif)
  );

  // Every output is a field of the state register.
  assign cmd_ready        = st.ready;
  assign cmd_done         = st.done;
  assign sense_result     = st.result;
  assign cal_found        = st.cal_found;
  assign stepper_phase_a  = st.phases[0];
  assign stepper_phase_b  = st.phases[1];
  assign stepper_phase_c  = st.phases[2];
  assign stepper_phase_d  = st.phases[3];
  assign head_choice_line = st.head_sel;

  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (reset);

  // Checks on the phase and sense line sequencing.
  a_idle_lines_low: assert property (
    (st.state == fhss_pkg::ST_IDLE && $past(st.state) == fhss_pkg::ST_IDLE)
      |-> st.phases == 4'h0)
    else $error("phase lines active while idle");
  a_start_two_lines: assert property (
    (st.state == fhss_pkg::ST_MOVE && $past(st.state) != fhss_pkg::ST_MOVE)
      |-> $countones(st.phases) == 2)
    else $error("movement did not open with two lines");
  a_fwd_start_pair: assert property (
    (st.state == fhss_pkg::ST_MOVE && $past(st.state) != fhss_pkg::ST_MOVE && !st.dir)
      |-> st.phases == pair_lines(2'h3, phase_order))
    else $error("forward start pair wrong");
  a_rev_start_pair: assert property (
    (st.state == fhss_pkg::ST_MOVE && $past(st.state) != fhss_pkg::ST_MOVE && st.dir)
      |-> st.phases == pair_lines(2'h0, phase_order))
    else $error("reverse start pair wrong");
  a_step_overlap: assert property (
    (st.state == fhss_pkg::ST_MOVE && $past(st.state) == fhss_pkg::ST_MOVE &&
     st.phases != $past(st.phases))
      |-> $countones(st.phases & $past(st.phases)) == 1 && $countones(st.phases) == 2)
    else $error("step boundary lost the overlap");
  a_hold_then_rest: assert property (
    (st.state == fhss_pkg::ST_HOLD && tif.expired && !st.overshoot &&
     st.op != fhss_pkg::OP_EJECT)
      |=> st.phases == 4'h0 && st.done && st.state == fhss_pkg::ST_IDLE)
    else $error("carriage not released after hold");
  a_hold_phase_a: assert property (
    st.state == fhss_pkg::ST_HOLD |-> st.phases == line_of(2'h0, phase_order))
    else $error("hold is not phase a alone");
  a_overshoot_back: assert property (
    (st.state == fhss_pkg::ST_HOLD && tif.expired && st.overshoot)
      |=> st.state == fhss_pkg::ST_MOVE && !st.dir && st.steps_left == 20'h0_0004)
    else $error("overshoot return not four forward steps");
  a_seek_ends_fwd: assert property (
    (st.state == fhss_pkg::ST_HOLD && !st.overshoot &&
     (st.op == fhss_pkg::OP_SEEK || st.op == fhss_pkg::OP_REZERO)) |-> !st.dir)
    else $error("seek ended with reverse motion");
  a_sense_disk_sel: assert property (
    (st.state == fhss_pkg::ST_SENSE && st.op != fhss_pkg::OP_SENSE_WP)
      |-> st.head_sel && st.phases == line_of(2'h0, phase_order))
    else $error("disk sense select wrong");
  a_sense_wp_sel: assert property (
    (st.state == fhss_pkg::ST_SENSE && st.op == fhss_pkg::OP_SENSE_WP)
      |-> !st.head_sel && st.phases == 4'h0)
    else $error("write protect sense select wrong");
  a_eject_runout: assert property (
    (st.state == fhss_pkg::ST_SENSE && tif.expired && st.op == fhss_pkg::OP_EJECT &&
     !st.sense_q)
      |=> st.state == fhss_pkg::ST_MOVE && st.dir && st.steps_left == 20'h0_0048)
    else $error("eject run-out not nine tracks");

endmodule

/* File: verif/fhss_drive_model.sv */
// Behavioural floppy drive: carriage position, sense line and calibration sensor.
module fhss_drive_model
#(
  parameter int EJECT_POS = 120
)
(
  input  wire logic       clk_sys,
  input  wire logic [3:0] phases,
  input  wire logic       head_choice_line,
  output logic            sense_pin,
  output logic            calib_pin
);
  timeunit 1ns;
  timeprecision 1ns;

  int         pos      = 0;
  logic       last_dir = 1'b0;
  logic       disk_in  = 1'b1;
  logic       wp       = 1'b0;
  logic       toggle   = 1'b0;
  logic [3:0] prev     = 4'h0;

  // First line, counting round the ring, of an adjacent energised pair, or -1 when the pattern is not a pair.
  function automatic int pair_of(input logic [3:0] p);
    case (p)
      4'b0011: return 0;
      4'b0110: return 1;
      4'b1100: return 2;
      4'b1001: return 3;
      default: return -1;
    endcase
  endfunction

  // Only pair-to-pair moves step the carriage; lone or released coils just hold it.
  always @(posedge clk_sys)
  begin
    toggle <= ~toggle;
    prev   <= phases;
    if (pair_of(prev) >= 0 && pair_of(phases) >= 0 && prev != phases)
    begin
      if (pair_of(phases) == (pair_of(prev) + 3) % 4)
      begin
        pos      = pos - 1;
        last_dir = 1'b0;
      end
      else
      begin
        pos      = pos + 1;
        last_dir = 1'b1;
      end
    end
    if (pos >= EJECT_POS)
      disk_in = 1'b0;
  end

  // Unselected sense conditions show a toggling level so no stale value can pass.
  assign sense_pin = (head_choice_line && phases[0]) ? disk_in :
                     (!head_choice_line && !phases[0]) ? wp : toggle;
  assign calib_pin = (pos <= 0);
endmodule

/* File: verif/fhss_sequencer_tb_top.sv */
// Self-checking testbench of the stepper sequencer against a drive model.
`define CHK(g, e) begin num_checks++; if ((g) !== (e)) begin n_mismatch++; \
  $display("ERROR t=%0t got=%0h exp=%0h", $time, (g), (e)); end end
module fhss_sequencer_tb_top;
  timeunit 1ns;
  timeprecision 1ns;

  localparam int EJ      = 120;
  localparam int CYC_MAX = 60000;

  logic        clk_sys, reset, cmd_valid, cmd_reverse, cmd_in_tracks;
  logic [2:0]  cmd_op;
  logic [15:0] cmd_count, period_accel, period_run, period_decel;
  logic        sense_pin, calib_pin, cmd_ready, cmd_done, sense_result, cal_found;
  logic        stepper_phase_a, stepper_phase_b, stepper_phase_c, stepper_phase_d;
  logic        head_choice_line, armed;
  logic [3:0]  ph, prev_ph, first_pat;
  logic [1:0]  snap;
  logic [31:0] seed = 32'h859a_27fd;
  int          n_mismatch = 0;
  int          num_checks = 0;
  int          cyc = 0;

  assign ph = {stepper_phase_d, stepper_phase_c, stepper_phase_b, stepper_phase_a};

  fhss_sequencer dut (.clk_sys(clk_sys), .reset(reset), .cmd_valid(cmd_valid),
    .cmd_op(cmd_op), .cmd_reverse(cmd_reverse), .cmd_count(cmd_count),
    .cmd_in_tracks(cmd_in_tracks), .period_accel(period_accel), .period_run(period_run),
    .period_decel(period_decel), .phase_order(8'he4), .sense_pin(sense_pin),
    .calib_pin(calib_pin), .cmd_ready(cmd_ready), .cmd_done(cmd_done),
    .sense_result(sense_result), .cal_found(cal_found), .stepper_phase_a(stepper_phase_a),
    .stepper_phase_b(stepper_phase_b), .stepper_phase_c(stepper_phase_c),
    .stepper_phase_d(stepper_phase_d), .head_choice_line(head_choice_line));

  fhss_drive_model #(.EJECT_POS(EJ)) drv (.clk_sys(clk_sys), .phases(ph),
    .head_choice_line(head_choice_line), .sense_pin(sense_pin), .calib_pin(calib_pin));

  // Free-running system clock.
  initial
  begin
    clk_sys = 1'b0;
    forever #50 clk_sys = ~clk_sys;
  end

  // Watch the phase lines: openings with the head line low take a pair, and every pair change keeps one coil.
  always @(posedge clk_sys)
  begin
    prev_ph <= ph;
    if (reset === 1'b0 && prev_ph === 4'h0 && ph !== 4'h0 && head_choice_line !== 1'b1)
    begin
      `CHK($countones(ph), 2)
      if (armed)
      begin
        first_pat <= ph;
        armed     <= 1'b0;
      end
    end
    if ($countones(prev_ph) == 2 && $countones(ph) == 2 && prev_ph !== ph)
      `CHK($countones(prev_ph & ph), 1)
  end

  // A hung sequence is cut short here and counted as a mismatch.
  always @(posedge clk_sys)
  begin
    cyc++;
    if (cyc == CYC_MAX)
    begin
      n_mismatch++;
      conclude();
    end
  end

  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction

  // Forward seek length from the take edge: opening, running patterns, last step, hold.
  // Each pattern stands exactly its period, and done is seen the edge the hold ends.
  function automatic int exp_lat(input int n, input int a, input int r, input int d);
    return (n >= 1) ? a + (n - 1) * r + 2 * d : a + d;
  endfunction

  task automatic conclude;
    $display("Counts: checks=%0d mismatches=%0d", num_checks, n_mismatch);
    if (n_mismatch == 0 && num_checks > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask

  task automatic set_periods(input int a, input int r, input int d);
    @(posedge clk_sys);
    period_accel <= 16'(a);
    period_run   <= 16'(r);
    period_decel <= 16'(d);
  endtask

  // One command: wait for ready, strobe for one edge, then count cycles up to done.
  task automatic issue(input logic [2:0] op, input logic rev, input logic [15:0] cnt,
                       input logic trk, input int lim, output int lat, output logic got);
    int n;
    n = 0;
    while (cmd_ready !== 1'b1 && n < 1000)
    begin
      @(posedge clk_sys);
      #1;
      n++;
    end
    @(posedge clk_sys);
    cmd_valid     <= 1'b1;
    cmd_op        <= op;
    cmd_reverse   <= rev;
    cmd_count     <= cnt;
    cmd_in_tracks <= trk;
    armed         <= 1'b1;
    @(posedge clk_sys);
    cmd_valid <= 1'b0;
    #1;
    lat = 0;
    got = 1'b0;
    while (!got && lat < lim)
    begin
      @(posedge clk_sys);
      #1;
      lat++;
      if (lat == 1)
        snap = {head_choice_line, stepper_phase_a};
      got = (cmd_done === 1'b1);
    end
  endtask

  task automatic seek(input logic rev, input logic [15:0] cnt, input logic trk);
    int   p0, steps, lat, pa, pr, pd;
    logic got;
    seed = lfsr(seed);
    pa = 1 + seed[1:0];
    pr = 1 + seed[3:2];
    pd = 1 + seed[5:4];
    set_periods(pa, pr, pd);
    p0 = drv.pos;
    steps = trk ? 8 * cnt : cnt;
    issue(3'(fhss_pkg::OP_SEEK), rev, cnt, trk, 20000, lat, got);
    `CHK(got, 1'b1)
    `CHK(first_pat, rev ? 4'b0011 : 4'b1001)
    `CHK(drv.pos, rev ? p0 + steps : p0 - steps)
    `CHK(drv.last_dir, 1'b0)
    `CHK(ph, 4'h0)
    if (!rev)
      `CHK(lat, exp_lat(steps, pa, pr, pd))
    $display("Test seek rev=%0d steps=%0d done", rev, steps);
  endtask

  initial
  begin
    int   lat, k, p0;
    logic got;
    reset = 1'b1;
    cmd_valid = 1'b0;
    cmd_op = 3'h0;
    cmd_reverse = 1'b0;
    cmd_count = 16'h0000;
    cmd_in_tracks = 1'b0;
    period_accel = 16'h0002;
    period_run = 16'h0002;
    period_decel = 16'h0002;
    armed = 1'b0;
    prev_ph = 4'h0;
    first_pat = 4'h0;
    repeat (2) @(posedge clk_sys);
    reset <= 1'b0;
    #1;
    `CHK(ph, 4'h0)
    `CHK({cmd_ready, cmd_done, head_choice_line, sense_result, cal_found}, 5'h00)
    drv.pos = 300;
    // Single eighth-track offsets both ways, a track-unit seek, then random seeks.
    seek(1'b0, 16'h0001, 1'b0);
    seek(1'b1, 16'h0001, 1'b0);
    seek(1'b0, 16'h0003, 1'b1);
    for (int i = 0; i < 6; i++)
    begin
      seed = lfsr(seed);
      seek(seed[0], 16'(2 + seed[8:1] % 20), seed[9]);
    end
    // Every combination of disk-present and write-protect, read both ways.
    // The carriage is parked inside the eject point so the model keeps the disk in.
    drv.pos = EJ / 2;
    for (int i = 0; i < 4; i++)
    begin
      drv.disk_in = i[0];
      drv.wp = i[1];
      issue(3'(fhss_pkg::OP_SENSE_DISK), 1'b0, 16'h0000, 1'b0, 100, lat, got);
      `CHK(snap, 2'b11)
      `CHK(sense_result, i[0])
      `CHK(lat, 32'(fhss_pkg::SENSE_SETTLE_CYC))
      issue(3'(fhss_pkg::OP_SENSE_WP), 1'b0, 16'h0000, 1'b0, 100, lat, got);
      `CHK(snap, 2'b00)
      `CHK(sense_result, i[1])
    end
    $display("Test sense done");
    // Rezero from a random distance must stop at the calibration reference.
    set_periods(3, 3, 3);
    seed = lfsr(seed);
    drv.pos = 20 + seed[5:0];
    issue(3'(fhss_pkg::OP_REZERO), 1'b0, 16'h0000, 1'b0, 20000, lat, got);
    `CHK(got, 1'b1)
    `CHK(cal_found, 1'b1)
    `CHK(drv.pos <= 0 && drv.pos >= -2, 1'b1)
    `CHK(first_pat, 4'b1001)
    $display("Test rezero done");
    // Eject probes outward in track steps, then runs nine more tracks.
    p0 = 40;
    drv.pos = p0;
    drv.disk_in = 1'b1;
    issue(3'(fhss_pkg::OP_EJECT), 1'b0, 16'h0000, 1'b0, 40000, lat, got);
    k = (EJ - p0 + 7) / 8;
    `CHK(got, 1'b1)
    `CHK(drv.pos, p0 + 8 * k + 72)
    `CHK(first_pat, 4'b0011)
    $display("Test eject done");
    // An unknown command gives no done and no motion.
    issue(3'h5, 1'b0, 16'h0004, 1'b0, 40, lat, got);
    `CHK(got, 1'b0)
    `CHK(ph, 4'h0)
    $display("Test unknown op done");
    seek(1'b1, 16'h0005, 1'b0);
    conclude();
  end
endmodule
